// >>> rtl/sffr_pkg.sv
// Package of constants for the sensor fault flag register block.
package sffr_pkg;

    // ****************************************************************
    // Word layout
    // ****************************************************************
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned BIT_FATAL   = 0;
    localparam int unsigned BIT_COMM    = 1;
    localparam int unsigned BIT_CAL     = 3;
    localparam int unsigned BIT_DIAG    = 4;
    localparam int unsigned BIT_RANGE   = 5;
    localparam int unsigned BIT_MEM     = 6;
    localparam int unsigned BIT_NOMEAS  = 7;
    localparam int unsigned BIT_LOWVOLT = 8;
    localparam int unsigned BIT_TIMEOUT = 9;
    localparam int unsigned BIT_BADSIG  = 10;
    localparam int unsigned BIT_HEATER  = 11;

    // Bits that are implemented; all others read as zero.
    localparam logic [WORD_W-1:0] IMPL_MASK  = 16'h0FFB;
    // Value of the fault word after reset: only the pending-measurement bit.
    localparam logic [WORD_W-1:0] RESET_WORD = 16'h0080;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_FAULT_WORD  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_FAULT_CLEAR = 16'h0001;

    // ****************************************************************
    // Synchroniser
    // ****************************************************************
    localparam int unsigned SYNC_STAGES = 2;

endpackage

// >>> rtl/sffr_level_sync.sv
// Two-stage synchroniser with a rising-edge pulse output.
module sffr_level_sync
    import sffr_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Asynchronous level in, synchronised level and edge out.
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out
);

    logic [SYNC_STAGES-1:0] stage_reg;
    logic [SYNC_STAGES-1:0] stage_next;
    logic                   seen_reg;
    logic                   seen_next;

    // Shift the level in; the edge detector reads only the last stage.
    always_comb begin
        stage_next = {stage_reg[SYNC_STAGES-2:0], async_in};
        seen_next  = stage_reg[SYNC_STAGES-1];
    end

    // Register the chain; the edge memory starts low so a level high at
    // reset release still produces one pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_reg <= '0;
            seen_reg  <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            seen_reg  <= seen_next;
        end
    end

    assign level_out = stage_reg[SYNC_STAGES-1];
    assign rise_out  = stage_reg[SYNC_STAGES-1] & ~seen_reg;

endmodule

// >>> rtl/sffr_fault_flags.sv
// Sensor fault flag word with its host register access port.
module sffr_fault_flags
    import sffr_pkg::*;
(
    // Clock and reset.
    input  wire logic              CLK,
    input  wire logic              RST,
    // Fault events from the sensor logic, one-cycle pulses.
    input  wire logic              AFE_INIT_FAIL,
    input  wire logic              CAL_FAIL,
    input  wire logic              DIAG_FAIL,
    input  wire logic              RANGE_ERR,
    input  wire logic              MEM_ERR,
    input  wire logic              HEATER_FAIL,
    // Measurement cycle reporting, one-cycle pulses.
    input  wire logic              MEAS_DONE,
    input  wire logic              MEAS_OK,
    input  wire logic              MEAS_TIMEOUT,
    input  wire logic              BAD_SAMPLE,
    // Retained low-supply reset indication from the supervisor, a level.
    input  wire logic              LOW_SUPPLY_RST,
    // Reset command from the command decoder, one-cycle pulse.
    input  wire logic              RESET_CMD,
    // Host register access.
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic              REG_RD,
    input  wire logic              REG_WR,
    input  wire logic [WORD_W-1:0] REG_WDATA,
    input  wire logic              ADDR_MAPPED_ELSE,
    output logic [WORD_W-1:0]      REG_RDATA,
    output logic                   REG_ACK,
    output logic                   REG_ERR,
    // Live fault word for the rest of the sensor.
    output logic [WORD_W-1:0]      FAULT_WORD
);

    // ****************************************************************
    // Overview
    // ****************************************************************
    // The fault word gathers one flag per sensor fault. Each flag is set
    // by a one-cycle event pulse and stays set until a clear reaches it,
    // so a host that polls slowly still sees every fault that happened.
    // A write of any value to the fault-clear register and the reset
    // command both clear every clearable flag at once.
    // The pending-measurement flag is never cleared by them; it drops
    // only when a measurement cycle finishes and returns only on reset.
    // The timeout and abnormal-signal flags also drop when a later
    // measurement cycle finishes successfully, while the diagnostic
    // summary flag stays until an explicit clear.
    // In every cycle the sets are applied after the clears, so a fault
    // that arrives together with a clear is never lost.
    // The low-supply indication comes from the supervisor outside this
    // clock domain; only its rising edge sets the flag, so a level that
    // stays high does not set it again after the host has cleared it.
    // Undescribed bits are masked to zero on every update, so host
    // writes can never reach them.
    // Register answers are registered and follow the access by one cycle.

    // ****************************************************************
    // Low-supply indication crossing
    // ****************************************************************
    logic low_lvl;
    logic low_rise;

    // The supervisor level is asynchronous, so it is synchronised first.
    sffr_level_sync u_low_sync (
        .clk       (CLK),
        .rst       (RST),
        .async_in  (LOW_SUPPLY_RST),
        .level_out (low_lvl),
        .rise_out  (low_rise)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic acc;
    logic hit_word;
    logic hit_clear;
    logic unmapped;
    logic clear_wr;

    // Classify every read or write by its address.
    always_comb begin
        acc       = REG_RD | REG_WR;
        hit_word  = 1'b0;
        hit_clear = 1'b0;
        if (REG_ADDR == ADDR_FAULT_WORD) begin
            hit_word = 1'b1;
        end else if (REG_ADDR == ADDR_FAULT_CLEAR) begin
            hit_clear = 1'b1;
        end
        unmapped = acc & ~hit_word & ~hit_clear & ~ADDR_MAPPED_ELSE;
        clear_wr = REG_WR & hit_clear;
    end

    // ****************************************************************
    // Fault word
    // ****************************************************************
    logic [WORD_W-1:0] flags_reg;
    logic [WORD_W-1:0] flags_next;
    logic              wipe;
    logic              diag_set;

    // Compute the next word; sets are applied after clears so an event in
    // the clearing cycle is kept.
    always_comb begin
        wipe       = clear_wr | RESET_CMD;
        diag_set   = DIAG_FAIL | MEAS_TIMEOUT | BAD_SAMPLE;
        flags_next = flags_reg;
        if (wipe) begin
            flags_next = flags_reg & ~IMPL_MASK;
            flags_next[BIT_NOMEAS] = flags_reg[BIT_NOMEAS];
        end
        if (RESET_CMD) begin
            flags_next[BIT_LOWVOLT] = 1'b0;
        end
        if (MEAS_OK) begin
            flags_next[BIT_TIMEOUT] = 1'b0;
            flags_next[BIT_BADSIG]  = 1'b0;
        end
        if (MEAS_DONE | MEAS_OK) begin
            flags_next[BIT_NOMEAS] = 1'b0;
        end
        if (AFE_INIT_FAIL) begin
            flags_next[BIT_FATAL] = 1'b1;
        end
        if (unmapped) begin
            flags_next[BIT_COMM] = 1'b1;
        end
        if (CAL_FAIL) begin
            flags_next[BIT_CAL] = 1'b1;
        end
        if (diag_set) begin
            flags_next[BIT_DIAG] = 1'b1;
        end
        if (RANGE_ERR) begin
            flags_next[BIT_RANGE] = 1'b1;
        end
        if (MEM_ERR) begin
            flags_next[BIT_MEM] = 1'b1;
        end
        if (low_rise) begin
            flags_next[BIT_LOWVOLT] = 1'b1;
        end
        if (MEAS_TIMEOUT) begin
            flags_next[BIT_TIMEOUT] = 1'b1;
        end
        if (BAD_SAMPLE) begin
            flags_next[BIT_BADSIG] = 1'b1;
        end
        if (HEATER_FAIL) begin
            flags_next[BIT_HEATER] = 1'b1;
        end
        flags_next = flags_next & IMPL_MASK;
    end

    // Register the word; reset is the power cycle.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flags_reg <= RESET_WORD;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ****************************************************************
    // Read data and answer
    // ****************************************************************
    logic [WORD_W-1:0] rdata_reg;
    logic [WORD_W-1:0] rdata_next;
    logic              ack_reg;
    logic              ack_next;
    logic              err_reg;
    logic              err_next;

    // Reads return the word as it stood when taken; the clear register
    // reads as zero. Reading changes no flag, except that a read of an unmapped address sets the communication flag.
    always_comb begin
        rdata_next = rdata_reg;
        ack_next   = acc & ~unmapped;
        err_next   = unmapped;
        if (REG_RD) begin
            if (hit_word) begin
                rdata_next = flags_reg;
            end else begin
                rdata_next = '0;
            end
        end
    end

    // Register the answer so the data output comes from flip-flops.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= '0;
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
            err_reg   <= err_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The synchronised supervisor level is only used through its edge.
    logic unused_low_lvl;
    assign unused_low_lvl = low_lvl;

    // The clear register acts on any written value, so write data is unused.
    logic unused_wdata;
    assign unused_wdata = ^REG_WDATA;

    assign REG_RDATA  = rdata_reg;
    assign REG_ACK    = ack_reg;
    assign REG_ERR    = err_reg;
    assign FAULT_WORD = flags_reg;

endmodule

// >>> tb/sffr_fault_flags_props.sv
// Checker of the fault flag register ports.
module sffr_props
    import sffr_pkg::*;
(
    // Clock, reset, events and host access.
    input wire logic              CLK,
    input wire logic              RST,
    input wire logic              CAL_FAIL,
    input wire logic              MEAS_OK,
    input wire logic              MEAS_TIMEOUT,
    input wire logic              BAD_SAMPLE,
    input wire logic              RESET_CMD,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic              REG_RD,
    input wire logic              REG_WR,
    input wire logic              ADDR_MAPPED_ELSE,
    // Outputs under watch.
    input wire logic              REG_ERR,
    input wire logic [WORD_W-1:0] FAULT_WORD
);
    timeunit 1ns;
    timeprecision 1ns;
    // All checks run on the one clock.
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Short name of the word, a clear request, and an access that hits no register.
    wire logic [WORD_W-1:0] w = FAULT_WORD;
    wire logic clr = RESET_CMD || (REG_WR && REG_ADDR == ADDR_FAULT_CLEAR);
    wire logic bad = (REG_RD || REG_WR) && REG_ADDR > ADDR_FAULT_CLEAR && !ADDR_MAPPED_ELSE;
    chk_cal_set: assert property (CAL_FAIL |=> w[3]) else $error("bit 3 not set");
    chk_timeout_diag: assert property (MEAS_TIMEOUT |=> w[9] && w[4]) else $error("bit 9 or 4 not set");
    chk_badsig_diag: assert property (BAD_SAMPLE |=> w[10] && w[4]) else $error("bit 10 or 4 not set");
    chk_good_clear: assert property (MEAS_OK && !MEAS_TIMEOUT && !BAD_SAMPLE |=> w[10:9] == 2'h0)
        else $error("bit 9 or 10 kept");
    chk_stray_err: assert property (bad |=> REG_ERR && w[1]) else $error("stray access not flagged");
    chk_spare_zero: assert property ((w & ~IMPL_MASK) == 16'h0000) else $error("spare bit set");
    chk_low_hold: assert property (w[8] && !clr |=> w[8]) else $error("bit 8 lost");
    chk_first_meas: assert property (!w[7] |=> !w[7]) else $error("bit 7 set again");
endmodule
bind sffr_fault_flags sffr_props u_props (.CLK, .RST, .CAL_FAIL, .MEAS_OK, .MEAS_TIMEOUT, .BAD_SAMPLE,
    .RESET_CMD, .REG_ADDR, .REG_RD, .REG_WR, .ADDR_MAPPED_ELSE, .REG_ERR, .FAULT_WORD);

// >>> tb/sffr_host.sv
// Host model that reads and writes the fault flag registers.
module sffr_host
    import sffr_pkg::*;
(
    // Clock and answer from the block.
    input wire logic              clk,
    input wire logic [WORD_W-1:0] rdata,
    input wire logic              ack,
    input wire logic              err,
    // Request to the block.
    output logic [ADDR_W-1:0]     addr,
    output logic                  rd,
    output logic                  wr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle at time zero, so nothing is requested during reset.
    initial begin
        addr = 16'hFFFF;
        rd = 1'h0;
        wr = 1'h0;
    end
    // Strobe one cycle, take the answer a cycle later; a released address is inverted.
    task automatic acc(input logic wrt, input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d,
                       output logic [1:0] ae);
        @(posedge clk);
        addr <= a;
        rd <= !wrt;
        wr <= wrt;
        @(posedge clk);
        addr <= ~a;
        rd <= 1'h0;
        wr <= 1'h0;
        #1;
        d = rdata;
        ae = {ack, err};
    endtask
endmodule

// >>> tb/tb_sensor_fault_flag_register.sv
// Self-checking testbench of the sensor fault flag register.
module tb_sensor_fault_flag_register
    import sffr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus, host wires and bookkeeping.
    logic              clk = 1'h0, rst = 1'h1, low = 1'h0, mapped = 1'h0;
    logic [10:0]       ev = 11'h000;
    logic [ADDR_W-1:0] addr;
    logic              rd, wr, ack, err;
    logic [1:0]        ae;
    logic [WORD_W-1:0] rdata, word, got;
    int                num_errors = 0, num_checks = 0, cyc = 0;
    // Host model and block; write data is tied.
    sffr_host host (.clk(clk), .rdata(rdata), .ack(ack), .err(err), .addr(addr), .rd(rd), .wr(wr));
    sffr_fault_flags DUT (.CLK(clk), .RST(rst), .AFE_INIT_FAIL(ev[0]), .CAL_FAIL(ev[1]), .DIAG_FAIL(ev[2]),
        .RANGE_ERR(ev[3]), .MEM_ERR(ev[4]), .HEATER_FAIL(ev[5]), .MEAS_DONE(ev[6]), .MEAS_OK(ev[7]),
        .MEAS_TIMEOUT(ev[8]), .BAD_SAMPLE(ev[9]), .RESET_CMD(ev[10]), .LOW_SUPPLY_RST(low), .REG_ADDR(addr),
        .REG_RD(rd), .REG_WR(wr), .REG_WDATA(16'hFFFF), .ADDR_MAPPED_ELSE(mapped), .REG_RDATA(rdata),
        .REG_ACK(ack), .REG_ERR(err), .FAULT_WORD(word));
    // Free-running clock.
    initial forever #4 clk = ~clk;
    // Compare and count.
    task automatic cmp(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle event pulse, then the settled word is compared.
    task automatic pulse(input logic [10:0] p, input logic [WORD_W-1:0] exp);
        @(posedge clk);
        ev <= p;
        @(posedge clk);
        ev <= 11'h000;
        #1;
        cmp(word, exp);
    endtask
    // Each event sets its bits, clears act as intended, set beats a good cycle.
    task automatic t_flags();
        host.acc(1'h0, ADDR_FAULT_WORD, got, ae);
        cmp(got, RESET_WORD);
        pulse(11'h001, 16'h0081);
        pulse(11'h002, 16'h0089);
        pulse(11'h004, 16'h0099);
        pulse(11'h008, 16'h00B9);
        pulse(11'h010, 16'h00F9);
        pulse(11'h020, 16'h08F9);
        host.acc(1'h1, ADDR_FAULT_CLEAR, got, ae);
        cmp(word, RESET_WORD);
        cmp({14'h0000, ae}, 16'h0002);
        pulse(11'h040, 16'h0000);
        pulse(11'h100, 16'h0210);
        pulse(11'h080, 16'h0010);
        pulse(11'h280, 16'h0410);
        pulse(11'h080, 16'h0010);
        pulse(11'h400, 16'h0000);
        $display("flag test done");
    endtask
    // Low supply reset, foreign and stray accesses, a write to the fault word that changes no flag (its answer is not checked), and repeated reads.
    task automatic t_bus();
        @(posedge clk);
        low <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        cmp(word, 16'h0100);
        pulse(11'h080, 16'h0100);
        @(posedge clk);
        mapped <= 1'h1;
        host.acc(1'h0, 16'h0005, got, ae);
        cmp({14'h0000, ae}, 16'h0002);
        cmp(word, 16'h0100);
        @(posedge clk);
        mapped <= 1'h0;
        host.acc(1'h0, 16'h0005, got, ae);
        cmp(got, 16'h0000);
        cmp({14'h0000, ae}, 16'h0001);
        host.acc(1'h1, ADDR_FAULT_WORD, got, ae);
        host.acc(1'h0, ADDR_FAULT_WORD, got, ae);
        cmp(got, 16'h0102);
        host.acc(1'h0, ADDR_FAULT_WORD, got, ae);
        cmp(got, 16'h0102);
        host.acc(1'h1, ADDR_FAULT_CLEAR, got, ae);
        cmp(word, 16'h0000);
        @(posedge clk);
        low <= 1'h0;
        $display("bus test done");
    endtask
    // Counts and verdict, then the end of the run.
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Main sequence after six reset cycles.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        t_flags();
        t_bus();
        stop_test();
    end
    // Cycle ceiling against a hang.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            num_errors++;
            stop_test();
        end
    end
endmodule
